// ===== rtl/sfcf_defs.svh
`ifndef SFCF_DEFS_SVH
`define SFCF_DEFS_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SFCF_OP_WR_ENABLE     8'h06
`define SFCF_OP_WR_DISABLE    8'h04
`define SFCF_OP_STATUS_READ   8'h05
`define SFCF_OP_STATUS_WRITE  8'h01
`define SFCF_OP_READ          8'h03
`define SFCF_OP_FAST_READ     8'h0b
`define SFCF_OP_DUAL_READ     8'h3b
`define SFCF_OP_PROGRAM       8'h02
`define SFCF_OP_SECTOR_ERASE  8'h20
`define SFCF_OP_BLOCK32_ERASE 8'h52
`define SFCF_OP_BLOCK64_ERASE 8'hd8
`define SFCF_OP_CHIP_ERASE_A  8'hc7
`define SFCF_OP_CHIP_ERASE_B  8'h60
`define SFCF_OP_POWER_DOWN    8'hb9
`define SFCF_OP_RELEASE       8'hab
`define SFCF_OP_MFR_DEV_ID    8'h90
`define SFCF_OP_READ_ID       8'h9f
`define SFCF_OP_UNIQUE_ID     8'h4b

// ----------------------------------------------------------------------
// Status byte layout and reset values
// ----------------------------------------------------------------------
`define SFCF_ST_BUSY          0
`define SFCF_ST_LATCH         1
`define SFCF_ST_PROT_LSB      2
`define SFCF_ST_PROT_MSB      4
`define SFCF_ST_LOCK          7
`define SFCF_PROT_RESET       3'h0
`define SFCF_LOCK_RESET       1'h0

// ----------------------------------------------------------------------
// Sequence counts
// ----------------------------------------------------------------------
`define SFCF_ADDR_LAST        3'h2
`define SFCF_ID_LAST          4'h2
`define SFCF_PIN_RESET        4'h9

`endif

// ===== rtl/sfcf_pkg.sv
package sfcf_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR   = 3'b010,
    ST_DUMMY  = 3'b011,
    ST_WDATA  = 3'b100,
    ST_RDATA  = 3'b101,
    ST_TAIL   = 3'b110,
    ST_IGNORE = 3'b111
  } sfcf_state_type;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_STATUS  = 3'b001,
    OP_PROGRAM = 3'b010,
    OP_SECTOR  = 3'b011,
    OP_BLOCK32 = 3'b100,
    OP_BLOCK64 = 3'b101,
    OP_CHIP    = 3'b110
  } sfcf_op_type;

endpackage : sfcf_pkg

// ===== rtl/sfcf_stream_if.sv
`timescale 1ns/1ps

interface sfcf_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface : sfcf_stream_if

// ===== rtl/sfcf_fifo.sv
`timescale 1ns/1ps

module sfcf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic      sys_clk,
  input  wire logic      rst,
  // Streams
  sfcf_stream_if.sink    push,
  sfcf_stream_if.source  pop
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire do_push = push.valid & push.ready;
  wire do_pop  = pop.valid & pop.ready;

  assign push.ready = count != (AW+1)'(DEPTH);
  assign pop.valid  = count != '0;
  assign pop.data   = mem[rd_ptr];

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_push && !do_pop)
        count <= count + 1'b1;
      else if (do_pop && !do_push)
        count <= count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (do_push)
      mem[wr_ptr] <= push.data;
  end

endmodule : sfcf_fifo

// ===== rtl/sfcf_front_end.sv
`timescale 1ns/1ps
`include "sfcf_defs.svh"

// Contract
// - Busy bit S0 is one while program, erase or status write runs.
// - Latch bit S1 resets to zero; when zero, writes and erases are refused.
// - Three protect bits S4..S2, reset zero, written by status write.
// - Protect bits change only outside hardware locked mode.
// - Whole-array erase runs only when all protect bits are zero.
// - Lock bit S7 plus low protect pin locks status bits against status write.
// - Everything shifts most significant bit first, latched on rising clock.
// - First eight bits after select falls are the opcode.
// - Read-type commands may end after any output bit; device deselects.
// - Write-type commands execute only if select rises on a byte boundary.
// - Partial last program byte writes nothing and keeps the latch set.
// - Decode write enable, write disable, status read and status write.
// - Decode read with an address phase, and fast read with address and dummy phases.
// - Dual read drives even bits on low line, odd on high.
// - Decode page program and sector erase with three address bytes.
// - Decode both block erases and both whole-array erase opcodes.
// - Decode power-down entry and release, release returning device code.
// - Manufacturer/device read alternates manufacturer and device bytes.
// - Identification read returns manufacturer then two id bytes, repeating.
// - Unique id read returns a 128-bit identifier after address and dummy.
// - Write enable sets the latch; host issues it before each write.
// - Latch clears on reset, write disable and operation completion.
// - Status write leaves S6, S5, S1, S0; S6 and S5 read zero.
// - In deep power-down only the release command is honoured.
// - Input sampled on rising clock, output shifted on falling clock.
module sfcf_front_end #(
  parameter logic [7:0]   MFR_CODE  = 8'h5a,         // Arbitrary value.
  parameter logic [7:0]   DEV_CODE  = 8'h21,         // Arbitrary value.
  parameter logic [15:0]  JEDEC_ID  = 16'h3a17,      // Arbitrary value.
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789abcdef_fedcba9876543210 // Arbitrary value.
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Serial pins
  input  wire logic         cs_n_pin,
  input  wire logic         sclk_pin,
  input  wire logic         wp_n_pin,
  input  wire logic         dual_line_low_in,
  output logic              dual_line_low_out,
  output logic              dual_line_low_oe,
  output logic              dual_line_high_out,
  output logic              dual_line_high_oe,
  // Array read port
  output logic [23:0]       rd_addr,
  input  wire logic [7:0]   rd_data,
  // Operation engine
  output logic              op_start,
  output sfcf_pkg::sfcf_op_type op_kind,
  output logic [23:0]       op_addr,
  output logic              prog_abort,
  input  wire logic         op_done,
  input  wire logic         area_protected,
  // Program data stream
  output logic [7:0]        prog_data,
  output logic              prog_valid,
  input  wire logic         prog_ready,
  // Status view
  output logic [7:0]        status_view,
  output logic              deep_power_down
);

  // --------------------------------------------------------------------
  // Decode functions
  // --------------------------------------------------------------------
  function automatic logic is_erase(input logic [7:0] op);
    is_erase = op == `SFCF_OP_SECTOR_ERASE || op == `SFCF_OP_BLOCK32_ERASE ||
               op == `SFCF_OP_BLOCK64_ERASE;
  endfunction : is_erase

  function automatic logic is_chip(input logic [7:0] op);
    is_chip = op == `SFCF_OP_CHIP_ERASE_A || op == `SFCF_OP_CHIP_ERASE_B;
  endfunction : is_chip

  function automatic sfcf_pkg::sfcf_state_type opcode_phase(input logic [7:0] op);
    case (op)
      `SFCF_OP_WR_ENABLE, `SFCF_OP_WR_DISABLE, `SFCF_OP_CHIP_ERASE_A,
      `SFCF_OP_CHIP_ERASE_B, `SFCF_OP_POWER_DOWN:
        opcode_phase = sfcf_pkg::ST_TAIL;
      `SFCF_OP_STATUS_WRITE, `SFCF_OP_PROGRAM:
        opcode_phase = (op == `SFCF_OP_PROGRAM) ? sfcf_pkg::ST_ADDR : sfcf_pkg::ST_WDATA;
      `SFCF_OP_STATUS_READ, `SFCF_OP_READ_ID:
        opcode_phase = sfcf_pkg::ST_RDATA;
      `SFCF_OP_READ, `SFCF_OP_FAST_READ, `SFCF_OP_DUAL_READ, `SFCF_OP_SECTOR_ERASE,
      `SFCF_OP_BLOCK32_ERASE, `SFCF_OP_BLOCK64_ERASE, `SFCF_OP_RELEASE,
      `SFCF_OP_MFR_DEV_ID, `SFCF_OP_UNIQUE_ID:
        opcode_phase = sfcf_pkg::ST_ADDR;
      default:
        opcode_phase = sfcf_pkg::ST_IGNORE;
    endcase
  endfunction : opcode_phase

  function automatic sfcf_pkg::sfcf_state_type addr_phase(input logic [7:0] op);
    if (op == `SFCF_OP_PROGRAM)
      addr_phase = sfcf_pkg::ST_WDATA;
    else if (is_erase(op))
      addr_phase = sfcf_pkg::ST_TAIL;
    else if (op == `SFCF_OP_FAST_READ || op == `SFCF_OP_DUAL_READ ||
             op == `SFCF_OP_UNIQUE_ID)
      addr_phase = sfcf_pkg::ST_DUMMY;
    else
      addr_phase = sfcf_pkg::ST_RDATA;
  endfunction : addr_phase

  function automatic sfcf_pkg::sfcf_op_type kind_of(input logic [7:0] op);
    case (op)
      `SFCF_OP_STATUS_WRITE:  kind_of = sfcf_pkg::OP_STATUS;
      `SFCF_OP_PROGRAM:       kind_of = sfcf_pkg::OP_PROGRAM;
      `SFCF_OP_SECTOR_ERASE:  kind_of = sfcf_pkg::OP_SECTOR;
      `SFCF_OP_BLOCK32_ERASE: kind_of = sfcf_pkg::OP_BLOCK32;
      `SFCF_OP_BLOCK64_ERASE: kind_of = sfcf_pkg::OP_BLOCK64;
      default:                kind_of = sfcf_pkg::OP_CHIP;
    endcase
  endfunction : kind_of

  // --------------------------------------------------------------------
  // Pin synchronisers and edges
  // --------------------------------------------------------------------
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [1:0] edge_d;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_s1 <= `SFCF_PIN_RESET;
      pin_s2 <= `SFCF_PIN_RESET;
      edge_d <= 2'h1;
    end
    else
    begin
      pin_s1 <= {wp_n_pin, dual_line_low_in, sclk_pin, cs_n_pin};
      pin_s2 <= pin_s1;
      edge_d <= pin_s2[1:0];
    end
  end

  wire cs_n    = pin_s2[0];
  wire sclk    = pin_s2[1];
  wire din     = pin_s2[2];
  wire wp_n    = pin_s2[3];
  wire rise    = sclk & ~edge_d[1] & ~cs_n;
  wire fall    = ~sclk & edge_d[1] & ~cs_n;
  wire cs_fall = ~cs_n & edge_d[0];
  wire cs_rise = cs_n & ~edge_d[0];

  // --------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------
  sfcf_pkg::sfcf_state_type state;
  sfcf_pkg::sfcf_state_type next_state;
  logic [6:0] in_shift;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic       busy_flag;
  logic       write_enable_latch;
  logic [2:0] protect_field;
  logic       status_lock_bit;
  logic [7:0] status;
  logic [7:0] wr_status;
  logic       overrun;

  wire [7:0] in_byte   = {in_shift, din};
  wire       byte_done = rise & (bit_cnt == 3'h7);
  wire       aligned   = bit_cnt == 3'h0;
  wire       hardware_locked_mode = status_lock_bit & ~wp_n;
  wire       op_allowed = deep_power_down ? (in_byte == `SFCF_OP_RELEASE)
                        : (!busy_flag || in_byte == `SFCF_OP_STATUS_READ);

  always_comb
  begin
    next_state = state;
    case (state)
      sfcf_pkg::ST_OPCODE:
        next_state = op_allowed ? opcode_phase(in_byte) : sfcf_pkg::ST_IGNORE;
      sfcf_pkg::ST_ADDR:
        next_state = (byte_cnt == `SFCF_ADDR_LAST) ? addr_phase(opcode) : state;
      sfcf_pkg::ST_DUMMY:
        next_state = sfcf_pkg::ST_RDATA;
      sfcf_pkg::ST_TAIL:
        next_state = sfcf_pkg::ST_IGNORE;
      sfcf_pkg::ST_WDATA:
        next_state = (opcode == `SFCF_OP_STATUS_WRITE && byte_cnt != 3'h0) ?
                     sfcf_pkg::ST_IGNORE : state;
      default:
        next_state = state;
    endcase
  end

  // Bits shift in on rising serial clock; deselect clears the byte count.
  always_ff @(posedge sys_clk)
  begin
    if (rst || cs_n)
    begin
      in_shift <= 7'h00;
      bit_cnt  <= 3'h0;
    end
    else if (rise)
    begin
      in_shift <= in_byte[6:0];
      bit_cnt  <= bit_cnt + 3'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || cs_n)
    begin
      state    <= sfcf_pkg::ST_IDLE;
      byte_cnt <= 3'h0;
    end
    else if (state == sfcf_pkg::ST_IDLE)
      state <= sfcf_pkg::ST_OPCODE;
    else if (byte_done)
    begin
      state    <= next_state;
      byte_cnt <= (next_state != state) ? 3'h0 :
                  (byte_cnt == 3'h7) ? byte_cnt : byte_cnt + 3'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      opcode    <= 8'h00;
      addr      <= 24'h000000;
      op_addr   <= 24'h000000;
      wr_status <= 8'h00;
    end
    else if (byte_done)
    begin
      if (state == sfcf_pkg::ST_OPCODE)
        opcode <= in_byte;
      if (state == sfcf_pkg::ST_ADDR)
        addr <= {addr[15:0], in_byte};
      if (state == sfcf_pkg::ST_ADDR && byte_cnt == `SFCF_ADDR_LAST)
        op_addr <= {addr[15:0], in_byte};
      if (state == sfcf_pkg::ST_WDATA && byte_cnt == 3'h0)
        wr_status <= in_byte;
    end
  end

  // --------------------------------------------------------------------
  // Data out
  // --------------------------------------------------------------------
  logic [2:0] out_cnt;
  logic [3:0] out_idx;
  logic [7:0] cur_byte;

  wire       enter_rd = byte_done & (next_state == sfcf_pkg::ST_RDATA) &
                        (state != sfcf_pkg::ST_RDATA);
  wire       dual     = opcode == `SFCF_OP_DUAL_READ;
  wire       last_bit = dual ? (out_cnt == 3'h3) : (out_cnt == 3'h7);
  wire       shift_out = fall & (state == sfcf_pkg::ST_RDATA);
  wire [2:0] hi_pos   = dual ? {~out_cnt[1:0], 1'b1} : ~out_cnt;
  wire [2:0] lo_pos   = {~out_cnt[1:0], 1'b0};
  wire [3:0] next_idx = (opcode == `SFCF_OP_READ_ID && out_idx == `SFCF_ID_LAST) ?
                        4'h0 : out_idx + 4'h1;

  always_comb
  begin
    case (opcode)
      `SFCF_OP_STATUS_READ: cur_byte = status;
      `SFCF_OP_READ_ID:
        cur_byte = (out_idx == 4'h0) ? MFR_CODE :
                   (out_idx == 4'h1) ? JEDEC_ID[15:8] : JEDEC_ID[7:0];
      `SFCF_OP_MFR_DEV_ID: cur_byte = out_idx[0] ? DEV_CODE : MFR_CODE;
      `SFCF_OP_RELEASE:    cur_byte = DEV_CODE;
      `SFCF_OP_UNIQUE_ID:  cur_byte = 8'(UNIQUE_ID >> {~out_idx, 3'b000});
      default:             cur_byte = rd_data;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || cs_n)
    begin
      dual_line_high_oe <= 1'b0;
      dual_line_low_oe  <= 1'b0;
      out_cnt           <= 3'h0;
      out_idx           <= 4'h0;
    end
    else if (enter_rd)
    begin
      dual_line_high_oe <= 1'b1;
      dual_line_low_oe  <= dual;
    end
    else if (shift_out)
    begin
      out_cnt <= last_bit ? 3'h0 : out_cnt + 3'h1;
      if (last_bit)
        out_idx <= next_idx;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dual_line_high_out <= 1'b0;
      dual_line_low_out  <= 1'b0;
      rd_addr            <= 24'h000000;
    end
    else if (enter_rd)
      rd_addr <= (state == sfcf_pkg::ST_ADDR) ? {addr[15:0], in_byte} : addr;
    else if (shift_out)
    begin
      dual_line_high_out <= cur_byte[hi_pos];
      dual_line_low_out  <= cur_byte[lo_pos];
      if (last_bit)
        rd_addr <= rd_addr + 24'h000001;
    end
  end

  // --------------------------------------------------------------------
  // Commit at deselect and status byte
  // --------------------------------------------------------------------
  wire cmd_end  = cs_rise & aligned & ~busy_flag;
  wire in_tail  = cmd_end & (state == sfcf_pkg::ST_TAIL);
  wire in_wdata = cmd_end & (state == sfcf_pkg::ST_WDATA);
  wire set_latch = in_tail & (opcode == `SFCF_OP_WR_ENABLE);
  wire clr_latch = in_tail & (opcode == `SFCF_OP_WR_DISABLE);
  wire do_status_write_cmd  = in_wdata & (opcode == `SFCF_OP_STATUS_WRITE) & (byte_cnt == 3'h1) &
                  write_enable_latch & ~hardware_locked_mode;
  wire do_prog  = in_wdata & (opcode == `SFCF_OP_PROGRAM) & (byte_cnt != 3'h0) &
                  write_enable_latch & ~area_protected & ~overrun;
  wire do_erase = in_tail & is_erase(opcode) & write_enable_latch & ~area_protected;
  wire do_chip  = in_tail & is_chip(opcode) & write_enable_latch &
                  (protect_field == 3'h0);
  wire do_sleep = in_tail & (opcode == `SFCF_OP_POWER_DOWN);
  wire start    = do_status_write_cmd | do_prog | do_erase | do_chip;
  wire end_prog = cs_rise & (state == sfcf_pkg::ST_WDATA) & (opcode == `SFCF_OP_PROGRAM);

  always_comb
  begin
    status = 8'h00;
    status[`SFCF_ST_BUSY]  = busy_flag;
    status[`SFCF_ST_LATCH] = write_enable_latch;
    status[`SFCF_ST_PROT_MSB:`SFCF_ST_PROT_LSB] = protect_field;
    status[`SFCF_ST_LOCK]  = status_lock_bit;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      busy_flag          <= 1'b0;
      write_enable_latch <= 1'b0;
      protect_field      <= `SFCF_PROT_RESET;
      status_lock_bit    <= `SFCF_LOCK_RESET;
    end
    else
    begin
      if (start)
        busy_flag <= 1'b1;
      else if (op_done)
        busy_flag <= 1'b0;
      if (set_latch)
        write_enable_latch <= 1'b1;
      else if (clr_latch || (op_done && busy_flag))
        write_enable_latch <= 1'b0;
      if (do_status_write_cmd)
      begin
        protect_field   <= wr_status[`SFCF_ST_PROT_MSB:`SFCF_ST_PROT_LSB];
        status_lock_bit <= wr_status[`SFCF_ST_LOCK];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      op_start        <= 1'b0;
      op_kind         <= sfcf_pkg::OP_NONE;
      prog_abort      <= 1'b0;
      deep_power_down <= 1'b0;
      status_view     <= 8'h00;
    end
    else
    begin
      op_start    <= start;
      prog_abort  <= end_prog & ~do_prog;
      status_view <= status;
      if (start)
        op_kind <= kind_of(opcode);
      if (do_sleep)
        deep_power_down <= 1'b1;
      else if (byte_done && state == sfcf_pkg::ST_OPCODE && in_byte == `SFCF_OP_RELEASE)
        deep_power_down <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Program byte buffer
  // --------------------------------------------------------------------
  logic push_valid;
  logic [7:0] push_data;

  sfcf_stream_if #(.WIDTH(8)) byte_in ();
  sfcf_stream_if #(.WIDTH(8)) byte_out ();

  assign byte_in.data   = push_data;
  assign byte_in.valid  = push_valid;
  assign byte_out.ready = prog_ready;
  assign prog_data      = byte_out.data;
  assign prog_valid     = byte_out.valid;

  // A byte that finds the buffer full spoils the program, which then aborts.
  always_ff @(posedge sys_clk)
  begin
    if (rst || cs_fall)
    begin
      push_valid <= 1'b0;
      push_data  <= 8'h00;
      overrun    <= 1'b0;
    end
    else
    begin
      push_valid <= byte_done & (state == sfcf_pkg::ST_WDATA) &
                    (opcode == `SFCF_OP_PROGRAM);
      push_data  <= in_byte;
      if (push_valid && !byte_in.ready)
        overrun <= 1'b1;
    end
  end

  sfcf_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .push    (byte_in),
    .pop     (byte_out)
  );

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_busy_start: assert property (op_start |-> busy_flag && !$past(busy_flag))
    else $error("busy flag not raised with operation start");
  chk_latch_refuse: assert property (op_start |-> $past(write_enable_latch))
    else $error("operation started without write enable latch");
  chk_protect_hold: assert property ($changed(protect_field) |->
    $past(do_status_write_cmd) && !$past(hardware_locked_mode))
    else $error("protect field changed outside an allowed status write");
  chk_chip_gate: assert property (op_start && op_kind == sfcf_pkg::OP_CHIP |->
    protect_field == 3'h0)
    else $error("whole array erase with protect bits set");
  chk_byte_align: assert property (op_start |-> $past(bit_cnt, 2) == 3'h0)
    else $error("operation started off a byte boundary");
  chk_abort_keeps: assert property (prog_abort |-> ##1 !op_start && $stable(write_enable_latch))
    else $error("aborted program changed the latch");
  chk_done_clears: assert property (op_done && busy_flag |=> !write_enable_latch && !busy_flag)
    else $error("completion did not clear latch and busy");
  chk_reserved_zero: assert property (status_view[6:5] == 2'b00)
    else $error("reserved status bits not zero");
  chk_sleep_quiet: assert property (deep_power_down && $past(deep_power_down) |-> !op_start)
    else $error("operation started in deep power-down");
  chk_out_fall: assert property ($changed(dual_line_high_out) |-> $past(fall))
    else $error("output changed away from a falling clock");

  cov_program: cover property (op_start && op_kind == sfcf_pkg::OP_PROGRAM);
  cov_dual_read: cover property (shift_out && dual_line_low_oe);
  cov_abort: cover property (prog_abort);

endmodule : sfcf_front_end

// ===== testbench/sfcf_host_model.sv
`timescale 1ns/1ps

module sfcf_host_model (
  // Serial pins
  output logic      cs_n_pin,
  output logic      sclk_pin,
  output logic      dual_line_low_in,
  input  wire logic so_wire
);
  initial
  begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    dual_line_low_in = 1'b0;
  end

  task automatic open();
    cs_n_pin = 1'b0;
    #24;
  endtask : open

  // Shifts n bits each way, one per 48 ns clock period.
  task automatic put(input logic [7:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      dual_line_low_in = b[i];
      #24 sclk_pin = 1'b1;
      r[i] = so_wire;
      #24 sclk_pin = 1'b0;
    end
  endtask : put

  task automatic close();
    #24 cs_n_pin = 1'b1;
    dual_line_low_in = ~dual_line_low_in;
    #300;
  endtask : close
endmodule : sfcf_host_model

// ===== testbench/sfcf_front_end_tb_top.sv
`timescale 1ns/1ps

module sfcf_front_end_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n_pin = 1'b1;
  logic op_done = 1'b0;
  logic cs_n_pin, sclk_pin, dual_line_low_in, dual_line_low_out, dual_line_low_oe;
  logic dual_line_high_out, dual_line_high_oe, op_start, prog_abort, prog_valid;
  logic deep_power_down;
  logic [23:0] rd_addr, op_addr;
  logic [7:0] rd_data, prog_data, status_view, last_prog;
  sfcf_pkg::sfcf_op_type op_kind;
  wire logic area_protected = 1'b0;
  wire logic prog_ready = 1'b1;
  wire logic so_wire = dual_line_high_oe ? dual_line_high_out : 1'b1;
  int bad_count = 0;
  int checked = 0;
  int starts = 0;
  int aborts = 0;
  int cnt = 0;
  assign rd_data = rd_addr[7:0];

  sfcf_front_end dut (.sys_clk, .rst, .cs_n_pin, .sclk_pin, .wp_n_pin, .dual_line_low_in,
    .dual_line_low_out, .dual_line_low_oe, .dual_line_high_out, .dual_line_high_oe,
    .rd_addr, .rd_data, .op_start, .op_kind, .op_addr, .prog_abort, .op_done,
    .area_protected, .prog_data, .prog_valid, .prog_ready, .status_view, .deep_power_down);
  sfcf_host_model host (.cs_n_pin, .sclk_pin, .dual_line_low_in, .so_wire);

  always #2.5 sys_clk = ~sys_clk;

  // Engine stand-in: finishes each accepted operation 400 cycles later.
  always @(posedge sys_clk)
  begin
    cnt <= op_start ? 400 : (cnt != 0 ? cnt - 1 : 0);
    op_done <= #1 (cnt == 1);
    starts <= starts + op_start;
    aborts <= aborts + prog_abort;
    if (prog_valid)
      last_prog <= prog_data;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] a, input int n, input logic [7:0] d);
    logic [7:0] r;
    host.open();
    host.put(a, 8, r);
    if (n > 0) host.put(d, n, r);
    host.close();
  endtask : cmd

  task automatic status_rd(input logic [7:0] e);
    logic [7:0] r;
    host.open();
    host.put(8'h05, 8, r);
    host.put(8'h00, 8, r);
    host.close();
    chk(r, e);
  endtask : status_rd

  task automatic t_latch();
    chk(status_view, 8'h00);
    cmd(8'h06, 0, 8'h00);
    status_rd(8'h02);
    cmd(8'h04, 0, 8'h00);
    status_rd(8'h00);
  endtask : t_latch

  task automatic t_status();
    int n;
    cmd(8'h06, 0, 8'h00);
    n = starts;
    cmd(8'h01, 8, 8'hec);
    chk(starts - n, 1);
    chk(op_kind, sfcf_pkg::OP_STATUS);
    status_rd(8'h8f);
    repeat (500) @(posedge sys_clk);
    status_rd(8'h8c);
  endtask : t_status

  task automatic t_refuse();
    int n;
    cmd(8'h06, 0, 8'h00);
    n = starts;
    cmd(8'hc7, 0, 8'h00);
    cmd(8'h60, 0, 8'h00);
    @(posedge sys_clk) #1 wp_n_pin = 1'b0;
    cmd(8'h01, 8, 8'h00);
    chk(starts - n, 0);
    status_rd(8'h8e);
    @(posedge sys_clk) #1 wp_n_pin = 1'b1;
    cmd(8'h01, 8, 8'h00);
    repeat (500) @(posedge sys_clk);
    status_rd(8'h00);
  endtask : t_refuse

  task automatic t_partial();
    logic [7:0] r;
    int n;
    cmd(8'h06, 0, 8'h00);
    n = aborts;
    host.open();
    host.put(8'h02, 8, r);
    repeat (3) host.put(8'h00, 8, r);
    host.put(8'ha5, 8, r);
    host.put(8'hf0, 4, r);
    host.close();
    chk(aborts - n, 1);
    chk(last_prog, 8'ha5);
    status_rd(8'h02);
  endtask : t_partial

  task automatic t_ident();
    logic [7:0] r0, r1, r2;
    host.open();
    host.put(8'h9f, 8, r0);
    host.put(8'h00, 8, r0);
    host.put(8'h00, 8, r1);
    host.put(8'h00, 8, r2);
    host.close();
    chk({r0, r1, r2}, 24'h5a3a17);
  endtask : t_ident

  task automatic t_read();
    logic [7:0] r0, r1;
    host.open();
    host.put(8'h03, 8, r0);
    repeat (2) host.put(8'h00, 8, r0);
    host.put(8'h10, 8, r0);
    host.put(8'h00, 8, r0);
    host.put(8'h00, 8, r1);
    host.close();
    chk({r0, r1}, 16'h1011);
    host.open();
    host.put(8'h0b, 8, r0);
    repeat (2) host.put(8'h00, 8, r0);
    host.put(8'h20, 8, r0);
    repeat (2) host.put(8'h00, 8, r0);
    host.close();
    chk(r0, 8'h20);
    chk(op_addr, 24'h000020);
  endtask : t_read

  task automatic t_sleep();
    logic [7:0] r;
    cmd(8'hb9, 0, 8'h00);
    chk(deep_power_down, 1'b1);
    status_rd(8'hff);
    host.open();
    host.put(8'hab, 8, r);
    repeat (4) host.put(8'h00, 8, r);
    host.close();
    chk(r, 8'h21);
    chk(deep_power_down, 1'b0);
  endtask : t_sleep

  task automatic report_and_stop();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    t_latch();
    t_status();
    t_refuse();
    t_partial();
    t_ident();
    t_read();
    t_sleep();
    report_and_stop();
  end

  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end
endmodule : sfcf_front_end_tb_top
